/* File: src/wsi_pkg.sv */
// Package for the wake source and interrupt pin configuration block.
// Assumes an 8-bit internal register port and one sample clock domain.
package wsi_pkg;

  // Register offsets on the internal register port
  localparam logic [7:0] WSI_WAKE_CTRL_OFS = 8'h2c;  // wake_and_irq_pin_control
  localparam logic [7:0] WSI_IRQ_EN_OFS    = 8'h2d;  // irq_source_enable

  // Field positions, wake_and_irq_pin_control
  localparam int WSI_FIFO_GATE_BIT  = 7;
  localparam int WSI_TRANSIENT_WAKE_ENABLE_BIT = 6;
  localparam int WSI_WAKE_ORIENT_BIT = 5;
  localparam int WSI_WAKE_PULSE_BIT = 4;
  localparam int WSI_WAKE_FALL_BIT  = 3;
  localparam int WSI_LEVEL_BIT      = 1;
  localparam int WSI_DRIVE_BIT      = 0;

  // Field positions, irq_source_enable (also event vector layout)
  localparam int WSI_SRC_SLEEP_WAKE = 7;
  localparam int WSI_SRC_FIFO       = 6;
  localparam int WSI_SRC_TRANS      = 5;
  localparam int WSI_SRC_ORIENT     = 4;
  localparam int WSI_SRC_PULSE      = 3;
  localparam int WSI_SRC_FALL       = 2;
  localparam int WSI_SRC_READY      = 0;

  // Writable bit masks; unused positions read as zero
  localparam logic [7:0] WSI_WAKE_CTRL_MASK = 8'hfb;
  localparam logic [7:0] WSI_IRQ_EN_MASK    = 8'hfd;

  // Values after reset
  localparam logic [7:0] WSI_WAKE_CTRL_RST = 8'h00;
  localparam logic [7:0] WSI_IRQ_EN_RST    = 8'h00;

  // FIFO input gate states
  typedef enum logic [0:0] {
    WSI_GATE_OPEN,
    WSI_GATE_HELD
  } wsi_gate_state_type;

  // Electrical setup of one interrupt pin
  typedef struct packed {
    logic level_high;  // 1: asserted as high
    logic open_drain;  // 1: only pulls low
  } wsi_pin_cfg_type;

endpackage

/* File: src/wsi_pin_drive.sv */
// One interrupt pin driver: polarity and push-pull or open-drain.
// Assumes the pad combines pin_o and pin_oe; no tri-state inside.
`timescale 1ns/100ps
`default_nettype none
module wsi_pin_drive
  import wsi_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire wsi_pin_cfg_type cfg,
  input  wire logic            irq_req,
  output logic                 pin_o,
  output logic                 pin_oe
);

  logic level;  // Wire level wanted for the pin

  // Polarity: asserted low unless level_high
  assign level = cfg.level_high ? irq_req : ~irq_req;

  // Registered pad controls
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_o  <= 1'b1;  // Deasserted, active low, push-pull
      pin_oe <= 1'b1;
    end else if (cfg.open_drain) begin
      // Only sinks current, so lines may be shared
      pin_o  <= 1'b0;
      pin_oe <= ~level;
    end else begin
      // Push-pull drives both levels
      pin_o  <= level;
      pin_oe <= 1'b1;
    end
  end

  a_pin_drive_mode : assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg.open_drain |=> (pin_o == 1'b0)) else $error("open drain pin drives high");

  a_pin_polarity : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!cfg.open_drain && !cfg.level_high && irq_req) |=> (pin_oe && !pin_o))
    else $error("active low pin not driven low");

endmodule
`default_nettype wire

/* File: src/wsi_fifo_gate.sv */
// FIFO input gate across wake/sleep mode changes.
// Assumes fifo_empty reflects the sample FIFO fill state each cycle.
`timescale 1ns/100ps
`default_nettype none
module wsi_fifo_gate
  import wsi_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic gate_en,
  input  wire logic sys_sleep,
  input  wire logic sample_valid,
  input  wire logic fifo_empty,
  output logic      fifo_flush,
  output logic      sample_store,
  output logic      gate_error,
  output logic      gate_held
);

  wsi_gate_state_type state_r;     // Gate state
  logic               mode_prev_r; // Last seen sleep level
  logic               mode_known_r;// Mode seen since reset
  logic               mode_change; // Wake/sleep transition

  // First cycle after reset only learns the mode, no spurious change
  assign mode_change = mode_known_r && (sys_sleep != mode_prev_r);
  assign gate_held   = (state_r == WSI_GATE_HELD);

  // Mode history
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_prev_r  <= 1'b0;
      mode_known_r <= 1'b0;
    end else begin
      mode_prev_r  <= sys_sleep;
      mode_known_r <= 1'b1;
    end
  end

  // Gate state machine
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= WSI_GATE_OPEN;
    end else begin
      case (state_r)
        WSI_GATE_OPEN: begin
          // Hold contents only when there is something to
          if (mode_change && gate_en && !fifo_empty)
            state_r <= WSI_GATE_HELD;
        end
        WSI_GATE_HELD: begin
          // Host emptied the FIFO, samples flow again
          if (fifo_empty)
            state_r <= WSI_GATE_OPEN;
        end
        default: state_r <= WSI_GATE_OPEN;
      endcase
    end
  end

  // Flush pulse on mode change while gating is off
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      fifo_flush <= 1'b0;
    else
      fifo_flush <= mode_change && !gate_en;
  end

  // Sample write strobe, dropped while held
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      sample_store <= 1'b0;
    else
      sample_store <= sample_valid && !gate_held;
  end

  // Error flag; on an empty FIFO the clear wins over a late sample
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      gate_error <= 1'b0;
    else if (gate_held && sample_valid && !fifo_empty)
      gate_error <= 1'b1;
    else if (fifo_empty)
      gate_error <= 1'b0;
  end

endmodule
`default_nettype wire

/* File: src/wsi_wake_irq_cfg.sv */
// Top of the wake source and interrupt pin configuration block.
// Assumes a synchronous internal register port from the serial
// interface, event flags from the detection functions and a routing
// vector from the pin routing register kept elsewhere.
//
// Overview of operation
// - Gate off: flush FIFO on mode change
// - Gate on: keep FIFO, drop samples until emptied
// - Late sample while gated sets gate error
// - Gate error holds until FIFO is empty
// - Transient wake bit: bypass or wake in sleep
// - Orientation wake bit: bypass or wake in sleep
// - Pulse wake bit: bypass or wake in sleep
// - Fall/motion wake bit: bypass or wake in sleep
// - Level bit: zero active low, one high
// - Drive bit: zero push-pull, one open-drain
// - Enable register bit order, bit 1 unused
// - Wake-control layout: gate, wakes, bit 2 unused
// - Enabled event flags reach the interrupt pins
`timescale 1ns/100ps
`default_nettype none
module wsi_wake_irq_cfg
  import wsi_pkg::*;
#(
  parameter int N_SRC = 8  // Width of the event and enable vectors
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_rvalid,
  input  wire logic             sys_sleep,
  input  wire logic             sample_valid,
  input  wire logic             fifo_empty,
  output logic                  fifo_flush,
  output logic                  sample_store,
  output logic                  fifo_gate_error,
  input  wire logic [N_SRC-1:0] src_event,
  input  wire logic [N_SRC-1:0] src_route,
  output logic      [N_SRC-1:0] irq_pending,
  output logic                  wake_request,
  output logic                  irq1_o,
  output logic                  irq1_oe,
  output logic                  irq2_o,
  output logic                  irq2_oe
);

  logic [7:0]      wake_ctrl_r;  // wake_and_irq_pin_control
  logic [7:0]      irq_en_r;     // irq_source_enable
  logic [N_SRC-1:0] wake_en;     // Wake enables in event layout
  logic [N_SRC-1:0] sleep_mask;  // Events allowed in current mode
  logic [N_SRC-1:0] live_event;  // Events after sleep bypass
  logic [N_SRC-1:0] enabled_evt; // Events passed to the controller
  wsi_pin_cfg_type pin_cfg;      // Shared pin setup
  logic            pin1_req;     // Assert request, pin 1
  logic            pin2_req;     // Assert request, pin 2
  logic            gate_held;    // FIFO input blocked

  // Keep only the bits that exist in a register
  function automatic logic [7:0] wsi_mask(input logic [7:0] v, input logic [7:0] m);
    return v & m;
  endfunction

  // Register write decode, one concern per register
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      wake_ctrl_r <= WSI_WAKE_CTRL_RST;
    else if (reg_wr && reg_addr == WSI_WAKE_CTRL_OFS)
      wake_ctrl_r <= wsi_mask(reg_wdata, WSI_WAKE_CTRL_MASK);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      irq_en_r <= WSI_IRQ_EN_RST;
    else if (reg_wr && reg_addr == WSI_IRQ_EN_OFS)
      irq_en_r <= wsi_mask(reg_wdata, WSI_IRQ_EN_MASK);
  end

  // Read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (!reg_rd)
        reg_rdata <= 8'h00;
      else if (reg_addr == WSI_WAKE_CTRL_OFS)
        reg_rdata <= wsi_mask(wake_ctrl_r, WSI_WAKE_CTRL_MASK);
      else if (reg_addr == WSI_IRQ_EN_OFS)
        reg_rdata <= wsi_mask(irq_en_r, WSI_IRQ_EN_MASK);
      else
        reg_rdata <= 8'h00;
    end
  end

  // Map the wake bits onto the event vector layout
  always_comb begin
    wake_en                     = '0;
    wake_en[WSI_SRC_TRANS]      = wake_ctrl_r[WSI_TRANSIENT_WAKE_ENABLE_BIT];
    wake_en[WSI_SRC_ORIENT]     = wake_ctrl_r[WSI_WAKE_ORIENT_BIT];
    wake_en[WSI_SRC_PULSE]      = wake_ctrl_r[WSI_WAKE_PULSE_BIT];
    wake_en[WSI_SRC_FALL]       = wake_ctrl_r[WSI_WAKE_FALL_BIT];
  end

  // In sleep the four detection functions are bypassed unless allowed;
  // other sources are not governed by wake bits and pass unchanged.
  always_comb begin
    sleep_mask = '1;
    if (sys_sleep) begin
      sleep_mask[WSI_SRC_TRANS]  = wake_en[WSI_SRC_TRANS];
      sleep_mask[WSI_SRC_ORIENT] = wake_en[WSI_SRC_ORIENT];
      sleep_mask[WSI_SRC_PULSE]  = wake_en[WSI_SRC_PULSE];
      sleep_mask[WSI_SRC_FALL]   = wake_en[WSI_SRC_FALL];
    end
  end

  assign live_event  = src_event & sleep_mask;
  // Only enabled sources reach the controller
  assign enabled_evt = live_event & irq_en_r[N_SRC-1:0];
  // Routing: one bit set sends a source to pin 1, clear to pin 2
  assign pin1_req    = |(enabled_evt & src_route);
  assign pin2_req    = |(enabled_evt & ~src_route);

  // Pending sources and wake request, registered for the outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_pending  <= '0;
      wake_request <= 1'b0;
    end else begin
      irq_pending  <= enabled_evt;
      // Wake needs an allowed function event while asleep
      wake_request <= sys_sleep && |(src_event & wake_en);
    end
  end

  // Same electrical setup for both pins
  assign pin_cfg.level_high = wake_ctrl_r[WSI_LEVEL_BIT];
  assign pin_cfg.open_drain = wake_ctrl_r[WSI_DRIVE_BIT];

  // Pin 1 driver
  wsi_pin_drive u_pin1 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cfg     (pin_cfg),
    .irq_req (pin1_req),
    .pin_o   (irq1_o),
    .pin_oe  (irq1_oe)
  );

  // Pin 2 driver
  wsi_pin_drive u_pin2 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cfg     (pin_cfg),
    .irq_req (pin2_req),
    .pin_o   (irq2_o),
    .pin_oe  (irq2_oe)
  );

  // FIFO gate across mode changes
  wsi_fifo_gate u_gate (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .gate_en      (wake_ctrl_r[WSI_FIFO_GATE_BIT]),
    .sys_sleep    (sys_sleep),
    .sample_valid (sample_valid),
    .fifo_empty   (fifo_empty),
    .fifo_flush   (fifo_flush),
    .sample_store (sample_store),
    .gate_error   (fifo_gate_error),
    .gate_held    (gate_held)
  );

  // Checks
  logic seen_r;        // A mode sample is known
  logic prev_sleep_r;  // Sleep level at the last edge
  // Own copy of the mode history, so the checks do not trust the gate's
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seen_r       <= 1'b0;
      prev_sleep_r <= 1'b0;
    end else begin
      seen_r       <= 1'b1;
      prev_sleep_r <= sys_sleep;
    end
  end

  // A wake/sleep change, never on the first edge after reset
  sequence s_mode_flip;
    seen_r && (sys_sleep != prev_sleep_r);
  endsequence

  sequence s_gate_closes;
    s_mode_flip ##0 wake_ctrl_r[WSI_FIFO_GATE_BIT] && !fifo_empty;
  endsequence

  a_flush_on_change : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_mode_flip ##0 !wake_ctrl_r[WSI_FIFO_GATE_BIT]) |=> fifo_flush)
    else $error("no flush on mode change with gate off");

  a_gate_no_flush : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_mode_flip ##0 wake_ctrl_r[WSI_FIFO_GATE_BIT]) |=> !fifo_flush)
    else $error("flush while gating");

  a_gate_drops_data : assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_gate_closes ##1 (sample_valid && !fifo_empty) |=> !sample_store)
    else $error("sample stored while gate held");

  a_gate_err_set : assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_gate_closes ##1 (sample_valid && !fifo_empty) |=> fifo_gate_error)
    else $error("gate error not raised");

  a_gate_err_hold : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fifo_gate_error && !fifo_empty) |=> fifo_gate_error)
    else $error("gate error dropped while FIFO not empty");

  a_gate_err_clear : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fifo_empty && !(gate_held && sample_valid)) |=> !fifo_gate_error)
    else $error("gate error not cleared on empty FIFO");

  a_trans_bypass : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sys_sleep && !wake_ctrl_r[WSI_TRANSIENT_WAKE_ENABLE_BIT]) |=> !irq_pending[WSI_SRC_TRANS])
    else $error("transient passed while bypassed");

  a_orient_wake : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sys_sleep && wake_ctrl_r[WSI_WAKE_ORIENT_BIT] && src_event[WSI_SRC_ORIENT])
    |=> wake_request) else $error("orientation did not wake");

  a_pulse_bypass : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sys_sleep && !wake_ctrl_r[WSI_WAKE_PULSE_BIT]) |=> !irq_pending[WSI_SRC_PULSE])
    else $error("pulse passed while bypassed");

  a_fall_wake : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sys_sleep && wake_ctrl_r[WSI_WAKE_FALL_BIT] && src_event[WSI_SRC_FALL])
    |=> wake_request) else $error("fall/motion did not wake");

  a_enable_pass : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!sys_sleep && src_event[WSI_SRC_READY] && irq_en_r[WSI_SRC_READY])
    |=> irq_pending[WSI_SRC_READY]) else $error("enabled event not passed");

  a_store_open : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!gate_held && sample_valid) |=> sample_store)
    else $error("sample dropped while gate open");

  // Wake and enable checks
  a_trans_wake : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sys_sleep && wake_ctrl_r[WSI_TRANSIENT_WAKE_ENABLE_BIT] && src_event[WSI_SRC_TRANS])
    |=> wake_request) else $error("transient did not wake");

  a_orient_bypass : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sys_sleep && !wake_ctrl_r[WSI_WAKE_ORIENT_BIT]) |=> !irq_pending[WSI_SRC_ORIENT])
    else $error("orientation passed while bypassed");

  a_pulse_wake : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sys_sleep && wake_ctrl_r[WSI_WAKE_PULSE_BIT] && src_event[WSI_SRC_PULSE])
    |=> wake_request) else $error("pulse did not wake");

  a_fall_bypass : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sys_sleep && !wake_ctrl_r[WSI_WAKE_FALL_BIT]) |=> !irq_pending[WSI_SRC_FALL])
    else $error("fall/motion passed while bypassed");

  a_awake_no_wake : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sys_sleep |=> !wake_request)
    else $error("wake request while awake");

  a_enable_block : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !irq_en_r[WSI_SRC_READY] |=> !irq_pending[WSI_SRC_READY])
    else $error("disabled event passed");

  a_sleep_ready : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sys_sleep && src_event[WSI_SRC_READY] && irq_en_r[WSI_SRC_READY])
    |=> irq_pending[WSI_SRC_READY]) else $error("ready event masked in sleep");

  // Register port checks; each unused bit is checked in its own register
  a_unused_zero : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == WSI_WAKE_CTRL_OFS) |=> (reg_rdata[2] == 1'b0))
    else $error("unused control bit read as one");

  a_unused_en_zero : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == WSI_IRQ_EN_OFS) |=> (reg_rdata[1] == 1'b0))
    else $error("unused enable bit read as one");

  a_unmapped_read : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr != WSI_WAKE_CTRL_OFS && reg_addr != WSI_IRQ_EN_OFS)
    |=> (reg_rdata == 8'h00)) else $error("unmapped read not zero");

  a_ctrl_write : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == WSI_WAKE_CTRL_OFS)
    |=> (wake_ctrl_r == ($past(reg_wdata) & WSI_WAKE_CTRL_MASK)))
    else $error("control write not stored");

  a_enable_write : assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == WSI_IRQ_EN_OFS)
    |=> (irq_en_r == ($past(reg_wdata) & WSI_IRQ_EN_MASK)))
    else $error("enable write not stored");

endmodule
`default_nettype wire

/* File: dv/wsi_host_model.sv */
// Host side model: the interrupt lines as the host sees them on the board.
// Assumes the block's pad value and enable pairs, one pull-up per line.
`timescale 1ns/100ps
`default_nettype none
module wsi_host_model
  import wsi_pkg::*;
(
  input  wire logic irq1_o,
  input  wire logic irq1_oe,
  input  wire logic irq2_o,
  input  wire logic irq2_oe,
  input  wire logic level_high,
  output logic      line1,
  output logic      line2,
  output logic      seen1,
  output logic      seen2
);
  // Released line reads the pull-up level, never a stale value;
  // lines stay separate because push-pull pins must not share one
  assign line1 = irq1_oe ? irq1_o : 1'b1;
  assign line2 = irq2_oe ? irq2_o : 1'b1;
  // Host decodes the event level it programmed itself
  assign seen1 = (line1 == level_high);
  assign seen2 = (line2 == level_high);
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the wake source and interrupt pin block.
// Assumes the package, design files and host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import wsi_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Value written
    logic [7:0] rdata;  // Value expected back
  } wsi_row_type;

  logic       ref_clk, rst_n, reg_wr, reg_rd, reg_rvalid, lvl;
  logic       sys_sleep, sample_valid, fifo_empty, fifo_flush;
  logic       sample_store, fifo_gate_error, wake_request;
  logic       irq1_o, irq1_oe, irq2_o, irq2_oe, line1, line2, seen1, seen2;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, n;
  logic [7:0] src_event, src_route, irq_pending;
  int         fails, samples_checked;
  // Unused bit positions, unmapped offset and reserved bits in one table
  wsi_row_type rows [7] = '{'{8'h2c, 8'hff, 8'hfb}, '{8'h2d, 8'hff, 8'hfd},
    '{8'h2c, 8'h84, 8'h80}, '{8'h2d, 8'h02, 8'h00}, '{8'h30, 8'hff, 8'h00},
    '{8'h2c, 8'h78, 8'h78}, '{8'h2d, 8'ha9, 8'ha9}};

  wsi_wake_irq_cfg #(.N_SRC(8)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sys_sleep(sys_sleep), .sample_valid(sample_valid),
    .fifo_empty(fifo_empty), .fifo_flush(fifo_flush), .sample_store(sample_store),
    .fifo_gate_error(fifo_gate_error), .src_event(src_event), .src_route(src_route),
    .irq_pending(irq_pending), .wake_request(wake_request), .irq1_o(irq1_o),
    .irq1_oe(irq1_oe), .irq2_o(irq2_o), .irq2_oe(irq2_oe));

  wsi_host_model host_u (
    .irq1_o(irq1_o), .irq1_oe(irq1_oe), .irq2_o(irq2_o), .irq2_oe(irq2_oe),
    .level_high(lvl), .line1(line1), .line2(line2), .seen1(seen1), .seen2(seen2));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Inputs move 1 ns after the rising edge, never on it
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Spare cycle after each strobe so no strobe is lowered and raised at once
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask

  // Read data stands one cycle only, so it is captured at once
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    v = reg_rdata;
    check({7'h00, reg_rvalid}, 8'h01);
    reg_rd = 1'b0;
    tick();
  endtask

  // Counts flush (sel 0) or store (sel 1) pulses over four cycles
  task automatic count4(input int sel, output logic [7:0] c);
    c = 8'h00;
    repeat (4) begin
      tick();
      sample_valid = 1'b0;
      c = c + {7'h00, (sel == 0) ? fifo_flush : sample_store};
    end
  endtask

  task automatic pin_case(input logic [7:0] cfg, input logic [7:0] route,
                          input logic [7:0] exp);
    wr(8'h2c, cfg);
    src_route = route;
    lvl = cfg[1];
    repeat (2) tick();
    check({2'h0, seen1, seen2, line1, line2, irq1_oe, irq2_oe}, exp);
  endtask

  task automatic report_and_stop();
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(5 * 20000);
    fails++;
    report_and_stop();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, sys_sleep, sample_valid, lvl} = '0;
    {reg_addr, reg_wdata, src_event, src_route} = '0;
    fifo_empty = 1'b1;
    fails = 0;
    samples_checked = 0;
    repeat (16) tick();
    rst_n = 1'b1;
    tick();
    // Reset: pins deasserted push-pull active low, registers clear
    check({4'h0, irq1_o, irq1_oe, irq2_o, irq2_oe}, 8'h0f);
    rd(8'h2c, d);
    check(d, 8'h00);
    rd(8'h2d, d);
    check(d, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      check(d, rows[i].rdata);
    end
    $display("register table test done");
    // Gate off: both mode directions flush once
    wr(8'h2c, 8'h00);
    fifo_empty = 1'b0;
    for (int k = 0; k < 2; k++) begin
      sys_sleep = ~sys_sleep;
      count4(0, n);
      check(n, 8'h01);
    end
    // Gate on with stored data: no flush, late sample dropped, error held
    wr(8'h2c, 8'h80);
    sys_sleep = 1'b1;
    tick();
    // Only the change edge could flush; the next sample is the late one
    check({7'h00, fifo_flush}, 8'h00);
    sample_valid = 1'b1;
    count4(1, n);
    check(n, 8'h00);
    check({7'h00, fifo_gate_error}, 8'h01);
    repeat (4) tick();
    check({7'h00, fifo_gate_error}, 8'h01);
    fifo_empty = 1'b1;
    repeat (2) tick();
    check({7'h00, fifo_gate_error}, 8'h00);
    sample_valid = 1'b1;
    count4(1, n);
    check(n, 8'h01);
    $display("fifo gate test done");
    // Sample-ready event through each pin setup
    wr(8'h2d, 8'hfd);
    src_event = 8'h01;
    sys_sleep = 1'b0;
    pin_case(8'h00, 8'hff, 8'h27);
    check(irq_pending, 8'h01);
    pin_case(8'h00, 8'h00, 8'h1b);
    pin_case(8'h02, 8'h00, 8'h17);
    pin_case(8'h01, 8'h00, 8'h19);
    pin_case(8'h03, 8'hff, 8'h29);
    wr(8'h2d, 8'h00);
    repeat (2) tick();
    check(irq_pending, 8'h00);
    $display("pin test done");
    // Sleep: each wake bit lets its own function through; ready never masked
    wr(8'h2d, 8'hfd);
    sys_sleep = 1'b1;
    for (int i = 0; i < 4; i++) begin
      src_event = (8'h20 >> i) | 8'h01;
      wr(8'h2c, 8'h00);
      repeat (2) tick();
      check({7'h00, wake_request}, 8'h00);
      check(irq_pending, 8'h01);
      wr(8'h2c, 8'h40 >> i);
      repeat (2) tick();
      check({7'h00, wake_request}, 8'h01);
      check(irq_pending, (8'h20 >> i) | 8'h01);
    end
    $display("wake source test done");
    // Second reset in mid-run clears the configuration
    rst_n = 1'b0;
    repeat (2) tick();
    rst_n = 1'b1;
    tick();
    rd(8'h2c, d);
    check(d, 8'h00);
    rd(8'h2d, d);
    check(d, 8'h00);
    $display("second reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
